/* File: port_link_power_consts.svh */
// constants for the port command register block: offsets, fields, codes
// assumes a 32-bit apb slave with a 12-bit byte address
//
// Contract
// - power request field sits in bits 31..28, software reads and writes it
// - a write while the link is idle starts the requested power transition
// - a write while the link is busy is ignored, nothing starts
// - a valid nonzero code is acted on, then the field returns to zero
// - a request for the current state starts nothing but still clears the field
// - a zero read means a new request may be written once the link has answered the last one
// - code 1h asks the link to go active
// - code 2h asks the link to go partial
// - code 6h asks the link to go to slumber
// - a device refusal leaves the link in its previous power state
// - codes 3h..5h and 7h..Fh are reserved and never start a transition
// - all read/write fields clear on global reset
// - bits 21..18 and 1 are written once after reset, read-only after
`ifndef PORT_LINK_POWER_CONSTS_SVH
`define PORT_LINK_POWER_CONSTS_SVH

// ============================================================
// addresses
`define PLP_ADDR_CMD 12'h000
`define PLP_ADDR_STAT 12'h004
`define PLP_ZERO32 32'h0000_0000

// ============================================================
// port command fields
`define PLP_REQ_HI 31
`define PLP_REQ_LO 28
`define PLP_RW_MASK 32'h0F02_0015
`define PLP_ONCE_MASK 32'h003C_0002
`define PLP_OVERRIDE_BIT 3
`define PLP_COLD_STATE_BIT 16
`define PLP_LIST_RUN_BIT 15
`define PLP_RECV_RUN_BIT 14
`define PLP_SWITCH_STATE_BIT 13
`define PLP_SLOT_LO 8
`define PLP_SLOT_W 5
`define PLP_DEEP_SEL_BIT 27
`define PLP_AGGR_EN_BIT 26
`define PLP_LED_EN_BIT 25
`define PLP_PACKET_BIT 24
`define PLP_EXT_PORT_BIT 21
`define PLP_COLD_FLAG_BIT 20
`define PLP_SWITCH_FLAG_BIT 19
`define PLP_HOTPLUG_BIT 18
`define PLP_MULT_BIT 17
`define PLP_RECV_EN_BIT 4
`define PLP_POWER_ON_BIT 2
`define PLP_SPIN_UP_BIT 1
`define PLP_LIST_GO_BIT 0

// ============================================================
// request codes and link states
`define PLP_CODE_IDLE 4'h0
`define PLP_CODE_ACTIVE 4'h1
`define PLP_CODE_PARTIAL 4'h2
`define PLP_CODE_SLUMBER 4'h6
`define PLP_LINK_ACTIVE 2'h0
`define PLP_LINK_PARTIAL 2'h1
`define PLP_LINK_SLUMBER 2'h2

// ============================================================
// status register fields
`define PLP_LINK_HI 1
`define PLP_LINK_LO 0
`define PLP_STAT_BUSY_BIT 2
`define PLP_STAT_REJ_BIT 3
`define PLP_STAT_IGN_BIT 4

`endif

/* File: port_link_power_pkg.sv */
// types shared by the port command register block
// assumes the constants header supplies all numeric values
`default_nettype none

package port_link_power_pkg;

    // ============================================================
    // power request sequencer
    typedef enum logic [1:0] {
        pm_idle,
        pm_issue,
        pm_wait
    } pm_state_t;

    typedef logic [3:0] req_code_t;
    typedef logic [1:0] link_state_t;

endpackage

`default_nettype wire

/* File: port_link_power_command.sv */
// port command register with its interface power request sequencer
// assumes an apb master on clk and a link layer on the same clock that
// reports idle, its power state, and completion or refusal of a request
`include "port_link_power_consts.svh"
`default_nettype none

module port_link_power_command (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic link_idle,
    input wire logic [1:0] link_power_state,
    input wire logic pm_done,
    input wire logic pm_rejected,
    output logic pm_req,
    output logic [1:0] pm_target,
    input wire logic cold_presence_state,
    input wire logic command_list_running,
    input wire logic receive_area_running,
    input wire logic presence_switch_state,
    input wire logic [4:0] current_command_slot,
    output logic aggressive_deep_select,
    output logic aggressive_power_enable,
    output logic packet_device_led_enable,
    output logic packet_device,
    output logic external_port_flag,
    output logic cold_presence_flag,
    output logic presence_switch_flag,
    output logic hotplug_capable_flag,
    output logic multiplier_attached,
    output logic receive_area_enable,
    output logic busy_override,
    output logic power_on_device,
    output logic spin_up_device,
    output logic command_list_go
);

    // ============================================================
    // helpers

    // only the three documented codes are requests
    function automatic logic code_valid(input port_link_power_pkg::req_code_t c);
        code_valid = (c == `PLP_CODE_ACTIVE) ||
                     (c == `PLP_CODE_PARTIAL) ||
                     (c == `PLP_CODE_SLUMBER);
    endfunction

    // both decoders feed the write strobes, the error flag and the read mux
    function automatic logic is_cmd_addr(input logic [11:0] a);
        is_cmd_addr = a == `PLP_ADDR_CMD;
    endfunction

    function automatic logic is_stat_addr(input logic [11:0] a);
        is_stat_addr = a == `PLP_ADDR_STAT;
    endfunction

    // once-only bits follow the first write after reset, later writes keep them
    function automatic logic [31:0] merge_ctrl(
        input logic [31:0] old_v,
        input logic [31:0] wr_v,
        input logic locked
    );
        if (locked) begin
            merge_ctrl = (old_v & ~`PLP_RW_MASK) | (wr_v & `PLP_RW_MASK);
        end else begin
            merge_ctrl = wr_v & (`PLP_RW_MASK | `PLP_ONCE_MASK);
        end
    endfunction

    // unmapped reads return zero so stale data never leaks onto the bus
    function automatic logic [31:0] read_mux(
        input logic [11:0] a,
        input logic [31:0] cmd_v,
        input logic [31:0] stat_v
    );
        if (is_cmd_addr(a)) begin
            read_mux = cmd_v;
        end else if (is_stat_addr(a)) begin
            read_mux = stat_v;
        end else begin
            read_mux = `PLP_ZERO32;
        end
    endfunction

    function automatic port_link_power_pkg::link_state_t code_target(
        input port_link_power_pkg::req_code_t c
    );
        if (c == `PLP_CODE_PARTIAL) begin
            code_target = `PLP_LINK_PARTIAL;
        end else if (c == `PLP_CODE_SLUMBER) begin
            code_target = `PLP_LINK_SLUMBER;
        end else begin
            code_target = `PLP_LINK_ACTIVE;
        end
    endfunction

    // ============================================================
    // bus phase decode
    logic setup_phase;
    logic access_done;
    logic wr_cmd;
    logic wr_stat;
    logic addr_ok;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign addr_ok = is_cmd_addr(paddr) || is_stat_addr(paddr);
    assign wr_cmd = access_done && pwrite && is_cmd_addr(paddr);
    assign wr_stat = access_done && pwrite && is_stat_addr(paddr);

    // ============================================================
    // storage
    logic [31:0] ctrl_q;
    logic once_locked_q;
    port_link_power_pkg::req_code_t req_q;
    port_link_power_pkg::req_code_t req_d;
    port_link_power_pkg::pm_state_t state_q;
    port_link_power_pkg::pm_state_t state_d;
    logic rejected_q;
    logic ignored_q;
    logic override_q;
    logic pm_req_q;
    port_link_power_pkg::link_state_t pm_target_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;

    port_link_power_pkg::req_code_t wr_code;
    logic wr_accept;
    logic wr_same;

    assign wr_code = pwdata[`PLP_REQ_HI:`PLP_REQ_LO];
    // a write is taken only with the link layer idle and the sequencer free
    assign wr_accept = wr_cmd && link_idle && (state_q == port_link_power_pkg::pm_idle);
    assign wr_same = code_target(wr_code) == link_power_state;

    // ============================================================
    // apb slave: one wait-free access cycle, answer from flops
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup_phase;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pslverr_q <= 1'b0;
        end else if (setup_phase) begin
            pslverr_q <= !addr_ok;
        end else if (access_done) begin
            pslverr_q <= 1'b0;
        end
    end

    logic [31:0] cmd_view;
    logic [31:0] stat_view;

    always_comb begin
        cmd_view = ctrl_q & (`PLP_RW_MASK | `PLP_ONCE_MASK);
        cmd_view[`PLP_REQ_HI:`PLP_REQ_LO] = req_q;
        cmd_view[`PLP_COLD_STATE_BIT] = cold_presence_state;
        cmd_view[`PLP_LIST_RUN_BIT] = command_list_running;
        cmd_view[`PLP_RECV_RUN_BIT] = receive_area_running;
        cmd_view[`PLP_SWITCH_STATE_BIT] = presence_switch_state;
        cmd_view[`PLP_SLOT_LO +: `PLP_SLOT_W] = current_command_slot;
    end

    always_comb begin
        stat_view = `PLP_ZERO32;
        stat_view[`PLP_LINK_HI:`PLP_LINK_LO] = link_power_state;
        stat_view[`PLP_STAT_BUSY_BIT] = state_q != port_link_power_pkg::pm_idle;
        stat_view[`PLP_STAT_REJ_BIT] = rejected_q;
        stat_view[`PLP_STAT_IGN_BIT] = ignored_q;
    end

    // read data is captured at setup so the answer is a flop
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prdata_q <= `PLP_ZERO32;
        end else if (setup_phase && !pwrite) begin
            prdata_q <= read_mux(paddr, cmd_view, stat_view);
        end
    end

    // ============================================================
    // plain control fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q <= `PLP_ZERO32;
        end else if (wr_cmd) begin
            // other fields of a refused power write still land
            ctrl_q <= merge_ctrl(ctrl_q, pwdata, once_locked_q);
        end
    end

    // first write after reset closes the once-only fields
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            once_locked_q <= 1'b0;
        end else if (wr_cmd) begin
            once_locked_q <= 1'b1;
        end
    end

    // write-only bit: a single-cycle pulse, never stored for readback
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            override_q <= 1'b0;
        end else begin
            override_q <= wr_cmd && pwdata[`PLP_OVERRIDE_BIT];
        end
    end

    // ============================================================
    // power request sequencer
    always_comb begin
        state_d = state_q;
        req_d = req_q;
        case (state_q)
            port_link_power_pkg::pm_idle: begin
                if (wr_accept && code_valid(wr_code)) begin
                    if (wr_same) begin
                        req_d = `PLP_CODE_IDLE;
                    end else begin
                        req_d = wr_code;
                        state_d = port_link_power_pkg::pm_issue;
                    end
                end
            end
            port_link_power_pkg::pm_issue: begin
                req_d = `PLP_CODE_IDLE;
                state_d = port_link_power_pkg::pm_wait;
            end
            // the field already reads zero here, so software may queue the
            // next write; it is refused until the link answers
            port_link_power_pkg::pm_wait: begin
                if (pm_done || pm_rejected) begin
                    state_d = port_link_power_pkg::pm_idle;
                end
            end
            default: begin
                state_d = port_link_power_pkg::pm_idle;
                req_d = `PLP_CODE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= port_link_power_pkg::pm_idle;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            req_q <= `PLP_CODE_IDLE;
        end else begin
            req_q <= req_d;
        end
    end

    // the link sees one pulse; low to other low is forwarded as is,
    // software is trusted to go through active first
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pm_req_q <= 1'b0;
        end else begin
            pm_req_q <= state_q == port_link_power_pkg::pm_issue;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pm_target_q <= `PLP_LINK_ACTIVE;
        end else if (state_q == port_link_power_pkg::pm_issue) begin
            pm_target_q <= code_target(req_q);
        end
    end

    // ============================================================
    // status flags, write one to clear, a new event beats the clear
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rejected_q <= 1'b0;
        end else if (state_q == port_link_power_pkg::pm_wait && pm_rejected) begin
            rejected_q <= 1'b1;
        end else if (wr_stat && pwdata[`PLP_STAT_REJ_BIT]) begin
            rejected_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ignored_q <= 1'b0;
        end else if (wr_cmd && !wr_accept) begin
            ignored_q <= 1'b1;
        end else if (wr_stat && pwdata[`PLP_STAT_IGN_BIT]) begin
            ignored_q <= 1'b0;
        end
    end

    // ============================================================
    // outputs
    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;
    assign pm_req = pm_req_q;
    assign pm_target = pm_target_q;
    assign busy_override = override_q;

    // plain read/write levels
    assign aggressive_deep_select = ctrl_q[`PLP_DEEP_SEL_BIT];
    assign aggressive_power_enable = ctrl_q[`PLP_AGGR_EN_BIT];
    assign packet_device_led_enable = ctrl_q[`PLP_LED_EN_BIT];
    assign packet_device = ctrl_q[`PLP_PACKET_BIT];
    assign multiplier_attached = ctrl_q[`PLP_MULT_BIT];
    assign receive_area_enable = ctrl_q[`PLP_RECV_EN_BIT];
    assign power_on_device = ctrl_q[`PLP_POWER_ON_BIT];
    assign command_list_go = ctrl_q[`PLP_LIST_GO_BIT];

    // once-only levels, frozen after the first command write
    assign external_port_flag = ctrl_q[`PLP_EXT_PORT_BIT];
    assign cold_presence_flag = ctrl_q[`PLP_COLD_FLAG_BIT];
    assign presence_switch_flag = ctrl_q[`PLP_SWITCH_FLAG_BIT];
    assign hotplug_capable_flag = ctrl_q[`PLP_HOTPLUG_BIT];
    assign spin_up_device = ctrl_q[`PLP_SPIN_UP_BIT];

endmodule

`default_nettype wire

/* File: port_link_power_monitor.sv */
// checker for the port command register block, bound to its top module
// assumes one clock domain and a synchronous active-low reset
`include "port_link_power_consts.svh"
`default_nettype none
// ==========================================
// checker
module port_link_power_monitor (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic link_idle,
    input wire logic [1:0] link_power_state,
    input wire logic pm_req,
    input wire logic [1:0] pm_target,
    input wire logic busy_override
);
    timeunit 1ns;
    timeprecision 1ps;
    logic cmd_wr;
    assign cmd_wr = pready && psel && penable && pwrite && (paddr == `PLP_ADDR_CMD);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    property p_req_cause; pm_req |-> $past(cmd_wr && link_idle, 2); endproperty
    a_req_cause: assert property (p_req_cause) else $error("request without idle write");
    property p_req_once; pm_req |=> !pm_req [*3]; endproperty
    a_req_once: assert property (p_req_once) else $error("request pulse repeated");
    property p_act; pm_req && $past(pwdata[31:28], 2) == `PLP_CODE_ACTIVE |-> pm_target == `PLP_LINK_ACTIVE; endproperty
    a_act: assert property (p_act) else $error("active code wrong target");
    property p_par; pm_req && $past(pwdata[31:28], 2) == `PLP_CODE_PARTIAL |-> pm_target == `PLP_LINK_PARTIAL; endproperty
    a_par: assert property (p_par) else $error("partial code wrong target");
    property p_slu; pm_req && $past(pwdata[31:28], 2) == `PLP_CODE_SLUMBER |-> pm_target == `PLP_LINK_SLUMBER; endproperty
    a_slu: assert property (p_slu) else $error("slumber code wrong target");
    property p_same; pm_req |-> pm_target != link_power_state; endproperty
    a_same: assert property (p_same) else $error("request for current state");
    property p_rsvd; cmd_wr && (pwdata[31:28] inside {[3:5], [7:15]}) |-> ##2 !pm_req; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved code started a request");
    property p_ign; cmd_wr && !link_idle |-> ##2 !pm_req; endproperty
    a_ign: assert property (p_ign) else $error("busy link write not ignored");
    property p_override; busy_override == $past(cmd_wr && pwdata[`PLP_OVERRIDE_BIT]); endproperty
    a_override: assert property (p_override) else $error("override pulse mismatch");
endmodule
bind port_link_power_command port_link_power_monitor u_mon (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .link_idle(link_idle), .link_power_state(link_power_state), .pm_req(pm_req),
    .pm_target(pm_target), .busy_override(busy_override));
`default_nettype wire

/* File: link_partner.sv */
// link layer and attached device model: answers power requests
// assumes requests arrive as one-cycle pulses on the same clock
`default_nettype none
// ==========================================
// link model
module link_partner (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic pm_req,
    input wire logic [1:0] pm_target,
    input wire logic reject,
    input wire logic slow,
    input wire logic hold_busy,
    output logic link_idle,
    output logic [1:0] link_power_state,
    output logic pm_done,
    output logic pm_rejected
);
    timeunit 1ns;
    timeprecision 1ps;
    logic run_q;
    logic [3:0] cnt_q;
    logic [1:0] tgt_q;
    assign link_idle = !hold_busy;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            run_q <= 1'b0;
            cnt_q <= 4'h0;
            tgt_q <= 2'h0;
            link_power_state <= 2'h0;
            pm_done <= 1'b0;
            pm_rejected <= 1'b0;
        end else begin
            pm_done <= 1'b0;
            pm_rejected <= 1'b0;
            if (pm_req) begin
                run_q <= 1'b1;
                tgt_q <= pm_target;
                cnt_q <= slow ? 4'h6 : 4'h0;
            end else if (run_q && cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end else if (run_q) begin
                run_q <= 1'b0;
                if (reject) begin
                    pm_rejected <= 1'b1;
                end else begin
                    link_power_state <= tgt_q;
                    pm_done <= 1'b1;
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: test_port_link_power_command.sv */
// self-checking bench for the port command register block
// assumes the link model sits on the block's link side
`include "port_link_power_consts.svh"
`default_nettype none
// ==========================================
// bench
module test_port_link_power_command;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, pm_req, busy_override;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic link_idle, pm_done, pm_rejected, reject = 0, slow = 0, hold_busy = 0, er;
    logic [1:0] link_power_state, pm_target;
    int err_count = 0, checks = 0, nreq = 0, cyc = 0;
    always #12.5 clk = ~clk;
    port_link_power_command u_port_link_power_command (.clk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pready, .prdata, .pslverr, .link_idle, .link_power_state, .pm_done, .pm_rejected,
        .pm_req, .pm_target, .cold_presence_state(1'b1), .command_list_running(1'b0),
        .receive_area_running(1'b1), .presence_switch_state(1'b0), .current_command_slot(5'h15),
        .aggressive_deep_select(), .aggressive_power_enable(), .packet_device_led_enable(),
        .packet_device(), .external_port_flag(), .cold_presence_flag(), .presence_switch_flag(),
        .hotplug_capable_flag(), .multiplier_attached(), .receive_area_enable(), .busy_override,
        .power_on_device(), .spin_up_device(), .command_list_go());
    link_partner u_link_partner (.clk, .rst_n, .pm_req, .pm_target, .reject, .slow, .hold_busy,
        .link_idle, .link_power_state, .pm_done, .pm_rejected);
    task automatic conclude();
        $display("errors %0d checks %0d", err_count, checks);
        if (err_count == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %0t got %h exp %h", $time, g, e);
        end
    endtask
    // apb master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge clk);
        end
        if (n == 20) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic do_req(input logic [3:0] c, input logic [1:0] ls, input int dq);
        int r0, n;
        r0 = nreq;
        n = 0;
        apb(1'b1, `PLP_ADDR_CMD, {c, 28'h000_0000});
        do begin
            apb(1'b0, `PLP_ADDR_STAT, 32'h0000_0000);
            n++;
        end while (rd[`PLP_STAT_BUSY_BIT] !== 1'b0 && n < 40);
        if (n == 40) err_count++;
        chk({30'h0, rd[1:0]}, {30'h0, ls});
        chk(nreq - r0, dq);
        apb(1'b0, `PLP_ADDR_CMD, 32'h0000_0000);
        chk({28'h0, rd[31:28]}, 32'h0000_0000);
    endtask
    always @(posedge clk) begin
        if (pm_req === 1'b1) nreq++;
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, `PLP_ADDR_CMD, 32'h0000_0000);
        chk(rd, 32'h0001_5500);
        apb(1'b1, `PLP_ADDR_CMD, 32'h0FFF_FFFF);
        apb(1'b0, `PLP_ADDR_CMD, 32'h0000_0000);
        chk(rd, 32'h0F3F_5517);
        apb(1'b1, `PLP_ADDR_CMD, 32'h0000_0000);
        apb(1'b0, `PLP_ADDR_CMD, 32'h0000_0000);
        chk(rd, 32'h003D_5502);
        do_req(4'h1, 2'h0, 0);
        do_req(4'h2, 2'h1, 1);
        do_req(4'h1, 2'h0, 1);
        slow <= 1'b1;
        do_req(4'h6, 2'h2, 1);
        slow <= 1'b0;
        do_req(4'h1, 2'h0, 1);
        for (int c = 3; c < 16; c++) if (c != 6) do_req(c[3:0], 2'h0, 0);
        reject <= 1'b1;
        do_req(4'h2, 2'h0, 1);
        chk({31'h0, rd[`PLP_OVERRIDE_BIT]}, 32'h0000_0000);
        apb(1'b0, `PLP_ADDR_STAT, 32'h0000_0000);
        chk({31'h0, rd[`PLP_STAT_REJ_BIT]}, 32'h0000_0001);
        reject <= 1'b0;
        hold_busy <= 1'b1;
        do_req(4'h6, 2'h0, 0);
        apb(1'b0, `PLP_ADDR_STAT, 32'h0000_0000);
        chk({31'h0, rd[`PLP_STAT_IGN_BIT]}, 32'h0000_0001);
        hold_busy <= 1'b0;
        apb(1'b0, 12'h010, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk({31'h0, er}, 32'h0000_0001);
        conclude();
    end
endmodule
`default_nettype wire
